/* File: inc/lsr_params.svh */
// constants of the light sensor register block
// What this block does
// R1: primary configuration resets to shutdown value
// R2: host writes both configuration registers together
// R3: integration code selects 3.125 to 400 ms
// R4: single-shot enable stops continuous conversion
// R5: trigger starts one measurement and self-clears on the same edge that starts it
// R6: interrupt enable gates threshold interrupt
// R7: reference powerdown bit, default one
// R8: channel powerdown stops both channels
// R9: quarter photodiode select for both channels
// R10: gain code selects one, two, 0.66, 0.5
// R11: persistence code selects 1, 2, 4, 8
// R12: host sets post power-up bit when ready
// R13: upper threshold at 0x04 and 0x05
// R14: lower threshold at 0x06 and 0x07
// R15: light result read-only at 0x10, 0x11
// R16: infrared result read-only at 0x12, 0x13
// R17: identity high byte: package, address, version
// R18: status bit 3 flags single-shot done
// R19: status bit 2 flags below-window event
// R20: status bit 1 flags above-window event
// R21: eight-bit command code selects the register
// R22: results held and readable while shut down
// R23: status read clears flags, releases interrupt
// R24: persistence counter of consecutive out-of-window results
`ifndef LSR_PARAMS_SVH
`define LSR_PARAMS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define LSR_CMD_CONF_PRIMARY 8'h00
`define LSR_CMD_CONF_SECONDARY 8'h01
`define LSR_CMD_UPPER_LOW 8'h04
`define LSR_CMD_UPPER_HIGH 8'h05
`define LSR_CMD_LOWER_LOW 8'h06
`define LSR_CMD_LOWER_HIGH 8'h07
`define LSR_CMD_LIGHT_LOW 8'h10
`define LSR_CMD_LIGHT_HIGH 8'h11
`define LSR_CMD_IR_LOW 8'h12
`define LSR_CMD_IR_HIGH 8'h13
`define LSR_CMD_ID_LOW 8'h14
`define LSR_CMD_ID_HIGH 8'h15
`define LSR_CMD_EVENT_FLAGS 8'h17

// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define LSR_CONF_PRIMARY_RST 8'h01
`define LSR_CONF_SECONDARY_RST 8'h00
`define LSR_WORD_RST 16'h0000
`define LSR_IT_MSB 6
`define LSR_IT_LSB 4
`define LSR_AF_BIT 3
`define LSR_TRIG_BIT 2
`define LSR_INTEN_BIT 1
`define LSR_REFPD_BIT 0
`define LSR_CHPD_BIT 7
`define LSR_PDQ_BIT 6
`define LSR_GAIN_MSB 4
`define LSR_GAIN_LSB 3
`define LSR_PERS_MSB 2
`define LSR_PERS_LSB 1
`define LSR_CAL_BIT 0
`define LSR_FLAG_DONE_BIT 3
`define LSR_FLAG_BELOW_BIT 2
`define LSR_FLAG_ABOVE_BIT 1
`define LSR_BUS_ADDR_A 7'h29
`define LSR_BUS_ADDR_B 7'h10
`define LSR_ADDR_OPT_A 2'b00
`define LSR_ADDR_OPT_B 2'b01
`define LSR_PACKAGE_CODE 2'b00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LSR_CLK_PERIOD_NS 100
`define LSR_INTEG_BASE_NS 3125000
`define LSR_INTEG_BASE_CYCLES \
	((`LSR_INTEG_BASE_NS + `LSR_CLK_PERIOD_NS - 1) / `LSR_CLK_PERIOD_NS)

`endif

/* File: inc/lsr_pkg.sv */
// types of the light sensor register block
package lsr_pkg;

	typedef enum logic [3:0] {
		LSR_BUS_IDLE = 4'h0,
		LSR_BUS_ADDR = 4'h1,
		LSR_BUS_ACK_ADDR = 4'h2,
		LSR_BUS_CMD = 4'h3,
		LSR_BUS_ACK_CMD = 4'h4,
		LSR_BUS_WRITE = 4'h5,
		LSR_BUS_ACK_WRITE = 4'h6,
		LSR_BUS_READ = 4'h7,
		LSR_BUS_READ_ACK = 4'h8
	} lsr_bus_state_type;

	typedef enum logic [1:0] {
		LSR_MEAS_IDLE = 2'b00,
		LSR_MEAS_INTEG = 2'b01
	} lsr_meas_state_type;

endpackage : lsr_pkg

/* File: rtl/lsr_top.sv */
// light sensor register block: serial slave, configuration, results and events
`timescale 1ns/100ps
`include "lsr_params.svh"

module lsr_top
	import lsr_pkg::*;
#(
	parameter logic [6:0] BUS_ADDR = `LSR_BUS_ADDR_A,
	parameter logic [7:0] IDENTITY_CODE = 8'h5a, // arbitrary value
	parameter logic [3:0] VERSION_CODE = 4'h2, // arbitrary value
	parameter int INTEG_BASE_CYCLES = `LSR_INTEG_BASE_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	output logic int_o,
	output logic int_oe_n_o,
	input wire logic [15:0] light_sample_i,
	input wire logic [15:0] ir_sample_i,
	output logic measure_active_o,
	output logic [2:0] integration_time_sel_o,
	output logic reference_powerdown_o,
	output logic channels_powerdown_o,
	output logic photodiode_quarter_sel_o,
	output logic [1:0] gain_sel_o,
	output logic post_powerup_set_bit_o
);

	// ----------------------------------------------------------------
	// pin synchronisers and bus events
	// ----------------------------------------------------------------
	logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
	logic sda_meta_reg, sda_sync_reg, sda_prev_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_meta_reg <= 1'b1;
			scl_sync_reg <= 1'b1;
			scl_prev_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_meta_reg <= scl_i;
			scl_sync_reg <= scl_meta_reg;
			scl_prev_reg <= scl_sync_reg;
			sda_meta_reg <= sda_i;
			sda_sync_reg <= sda_meta_reg;
			sda_prev_reg <= sda_sync_reg;
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise = scl_sync_reg & ~scl_prev_reg;
	assign scl_fall = ~scl_sync_reg & scl_prev_reg;
	assign start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
	assign stop_det = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [7:0] conf_primary_reg, conf_secondary_reg;
	logic [15:0] upper_threshold_reg, lower_threshold_reg;
	logic [15:0] light_result_reg, infrared_result_reg;
	logic single_shot_done_flag_reg, below_window_flag_reg, above_window_flag_reg;
	logic wr_pulse;
	logic [7:0] wr_cmd, wr_data;
	logic flags_read_pulse;
	logic trig_clear_pulse;
	logic result_pulse, below_now, above_now, persist_hit;

	function automatic logic [7:0] read_mux(input logic [7:0] cmd);
		logic [7:0] val;
		val = 8'h00;
		case (cmd)
			`LSR_CMD_CONF_PRIMARY: val = conf_primary_reg;
			`LSR_CMD_CONF_SECONDARY: val = conf_secondary_reg;
			`LSR_CMD_UPPER_LOW: val = upper_threshold_reg[7:0]; // R13
			`LSR_CMD_UPPER_HIGH: val = upper_threshold_reg[15:8]; // R13
			`LSR_CMD_LOWER_LOW: val = lower_threshold_reg[7:0]; // R14
			`LSR_CMD_LOWER_HIGH: val = lower_threshold_reg[15:8]; // R14
			`LSR_CMD_LIGHT_LOW: val = light_result_reg[7:0]; // R15
			`LSR_CMD_LIGHT_HIGH: val = light_result_reg[15:8]; // R15
			`LSR_CMD_IR_LOW: val = infrared_result_reg[7:0]; // R16
			`LSR_CMD_IR_HIGH: val = infrared_result_reg[15:8]; // R16
			`LSR_CMD_ID_LOW: val = IDENTITY_CODE;
			`LSR_CMD_ID_HIGH: begin
				val[7:6] = `LSR_PACKAGE_CODE; // R17
				val[5:4] = (BUS_ADDR == `LSR_BUS_ADDR_B) ? `LSR_ADDR_OPT_B
					: `LSR_ADDR_OPT_A; // R17
				val[3:0] = VERSION_CODE; // R17
			end
			`LSR_CMD_EVENT_FLAGS: begin
				val[`LSR_FLAG_DONE_BIT] = single_shot_done_flag_reg; // R18
				val[`LSR_FLAG_BELOW_BIT] = below_window_flag_reg; // R19
				val[`LSR_FLAG_ABOVE_BIT] = above_window_flag_reg; // R20
			end
			default: val = 8'h00;
		endcase
		return val;
	endfunction : read_mux

	// host writes; the trigger bit is cleared by the engine unless rewritten
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			conf_primary_reg <= `LSR_CONF_PRIMARY_RST; // R1
			conf_secondary_reg <= `LSR_CONF_SECONDARY_RST;
			upper_threshold_reg <= `LSR_WORD_RST;
			lower_threshold_reg <= `LSR_WORD_RST;
		end else if (wr_pulse) begin
			case (wr_cmd)
				`LSR_CMD_CONF_PRIMARY: conf_primary_reg <= wr_data;
				`LSR_CMD_CONF_SECONDARY: conf_secondary_reg <= wr_data; // R12
				`LSR_CMD_UPPER_LOW: upper_threshold_reg[7:0] <= wr_data; // R13
				`LSR_CMD_UPPER_HIGH: upper_threshold_reg[15:8] <= wr_data; // R13
				`LSR_CMD_LOWER_LOW: lower_threshold_reg[7:0] <= wr_data; // R14
				`LSR_CMD_LOWER_HIGH: lower_threshold_reg[15:8] <= wr_data; // R14
				default: ;
			endcase
		end else if (trig_clear_pulse) begin
			conf_primary_reg[`LSR_TRIG_BIT] <= 1'b0; // R5
		end
	end

	logic [2:0] it_sel;
	logic af_en, trig_bit, int_en, ref_pd, ch_pd;
	logic [1:0] pers_sel;
	assign it_sel = conf_primary_reg[`LSR_IT_MSB:`LSR_IT_LSB];
	assign af_en = conf_primary_reg[`LSR_AF_BIT];
	assign trig_bit = conf_primary_reg[`LSR_TRIG_BIT];
	assign int_en = conf_primary_reg[`LSR_INTEN_BIT];
	assign ref_pd = conf_primary_reg[`LSR_REFPD_BIT];
	assign ch_pd = conf_secondary_reg[`LSR_CHPD_BIT];
	assign pers_sel = conf_secondary_reg[`LSR_PERS_MSB:`LSR_PERS_LSB];

	assign integration_time_sel_o = it_sel; // R3
	assign reference_powerdown_o = ref_pd; // R7
	assign channels_powerdown_o = ch_pd; // R8
	assign photodiode_quarter_sel_o = conf_secondary_reg[`LSR_PDQ_BIT]; // R9
	assign gain_sel_o = conf_secondary_reg[`LSR_GAIN_MSB:`LSR_GAIN_LSB]; // R10
	assign post_powerup_set_bit_o = conf_secondary_reg[`LSR_CAL_BIT];

	// ----------------------------------------------------------------
	// serial slave
	// ----------------------------------------------------------------
	lsr_bus_state_type bus_state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] rx_reg, tx_reg, ptr_reg;
	logic rw_reg, sda_low_reg, master_nack_reg;
	logic wr_pulse_reg, flags_read_reg;
	logic [7:0] wr_cmd_reg, wr_data_reg;
	logic [7:0] rd_byte;

	always_comb begin
		rd_byte = read_mux(ptr_reg);
	end

	assign wr_pulse = wr_pulse_reg;
	assign wr_cmd = wr_cmd_reg;
	assign wr_data = wr_data_reg;
	assign flags_read_pulse = flags_read_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_state_reg <= LSR_BUS_IDLE;
			bit_cnt_reg <= 4'h0;
			rx_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			master_nack_reg <= 1'b0;
			wr_pulse_reg <= 1'b0;
			wr_cmd_reg <= 8'h00;
			wr_data_reg <= 8'h00;
			flags_read_reg <= 1'b0;
		end else begin
			wr_pulse_reg <= 1'b0;
			flags_read_reg <= 1'b0;
			if (start_det) begin
				bus_state_reg <= LSR_BUS_ADDR;
				bit_cnt_reg <= 4'h0;
				sda_low_reg <= 1'b0;
			end else if (stop_det) begin
				bus_state_reg <= LSR_BUS_IDLE;
				sda_low_reg <= 1'b0;
			end else if (scl_rise) begin
				case (bus_state_reg)
					LSR_BUS_ADDR, LSR_BUS_CMD, LSR_BUS_WRITE: begin
						rx_reg <= {rx_reg[6:0], sda_sync_reg};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					LSR_BUS_READ_ACK: master_nack_reg <= sda_sync_reg;
					default: ;
				endcase
			end else if (scl_fall) begin
				case (bus_state_reg)
					LSR_BUS_ADDR: begin
						if (bit_cnt_reg == 4'h8) begin
							if (rx_reg[7:1] == BUS_ADDR) begin
								bus_state_reg <= LSR_BUS_ACK_ADDR;
								rw_reg <= rx_reg[0];
								sda_low_reg <= 1'b1;
							end else begin
								bus_state_reg <= LSR_BUS_IDLE;
							end
						end
					end
					LSR_BUS_ACK_ADDR: begin
						if (rw_reg) begin
							tx_reg <= rd_byte;
							sda_low_reg <= ~rd_byte[7];
							flags_read_reg <= (ptr_reg == `LSR_CMD_EVENT_FLAGS); // R23
							ptr_reg <= ptr_reg + 8'h01;
							bit_cnt_reg <= 4'h1;
							bus_state_reg <= LSR_BUS_READ;
						end else begin
							sda_low_reg <= 1'b0;
							bit_cnt_reg <= 4'h0;
							bus_state_reg <= LSR_BUS_CMD;
						end
					end
					LSR_BUS_CMD: begin
						if (bit_cnt_reg == 4'h8) begin
							ptr_reg <= rx_reg; // R21
							sda_low_reg <= 1'b1;
							bus_state_reg <= LSR_BUS_ACK_CMD;
						end
					end
					LSR_BUS_ACK_CMD, LSR_BUS_ACK_WRITE: begin
						sda_low_reg <= 1'b0;
						bit_cnt_reg <= 4'h0;
						bus_state_reg <= LSR_BUS_WRITE;
					end
					LSR_BUS_WRITE: begin
						if (bit_cnt_reg == 4'h8) begin
							wr_pulse_reg <= 1'b1;
							wr_cmd_reg <= ptr_reg;
							wr_data_reg <= rx_reg;
							ptr_reg <= ptr_reg + 8'h01; // R2
							sda_low_reg <= 1'b1;
							bus_state_reg <= LSR_BUS_ACK_WRITE;
						end
					end
					LSR_BUS_READ: begin
						if (bit_cnt_reg == 4'h8) begin
							sda_low_reg <= 1'b0;
							bus_state_reg <= LSR_BUS_READ_ACK;
						end else begin
							tx_reg <= {tx_reg[6:0], 1'b0};
							sda_low_reg <= ~tx_reg[6];
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
					LSR_BUS_READ_ACK: begin
						if (master_nack_reg) begin
							bus_state_reg <= LSR_BUS_IDLE;
						end else begin
							tx_reg <= rd_byte;
							sda_low_reg <= ~rd_byte[7];
							flags_read_reg <= (ptr_reg == `LSR_CMD_EVENT_FLAGS); // R23
							ptr_reg <= ptr_reg + 8'h01;
							bit_cnt_reg <= 4'h1;
							bus_state_reg <= LSR_BUS_READ;
						end
					end
					default: bus_state_reg <= LSR_BUS_IDLE;
				endcase
			end
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe_n_o = ~sda_low_reg;

	// ----------------------------------------------------------------
	// measurement engine
	// ----------------------------------------------------------------
	lsr_meas_state_type meas_state_reg;
	logic [31:0] integ_cnt_reg;
	logic [31:0] integ_len;
	logic running;

	assign running = ~ref_pd & ~ch_pd; // R7 R8
	assign integ_len = 32'(INTEG_BASE_CYCLES) << it_sel; // R3
	assign result_pulse = (meas_state_reg == LSR_MEAS_INTEG) && running
		&& (integ_cnt_reg == integ_len - 32'd1);
	assign trig_clear_pulse = (meas_state_reg == LSR_MEAS_IDLE) && running
		&& af_en && trig_bit && ~wr_pulse; // R5
	assign measure_active_o = (meas_state_reg == LSR_MEAS_INTEG);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meas_state_reg <= LSR_MEAS_IDLE;
			integ_cnt_reg <= 32'd0;
		end else begin
			case (meas_state_reg)
				LSR_MEAS_IDLE: begin
					integ_cnt_reg <= 32'd0;
					if (running && (~af_en || trig_clear_pulse)) begin // R4 R5
						meas_state_reg <= LSR_MEAS_INTEG;
					end
				end
				LSR_MEAS_INTEG: begin
					if (~running) begin
						meas_state_reg <= LSR_MEAS_IDLE;
						integ_cnt_reg <= 32'd0;
					end else if (result_pulse) begin
						integ_cnt_reg <= 32'd0;
						if (af_en) begin
							meas_state_reg <= LSR_MEAS_IDLE; // R4
						end
					end else begin
						integ_cnt_reg <= integ_cnt_reg + 32'd1;
					end
				end
				default: meas_state_reg <= LSR_MEAS_IDLE;
			endcase
		end
	end

	// results change only at the end of a measurement, so they hold while shut down
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			light_result_reg <= `LSR_WORD_RST;
			infrared_result_reg <= `LSR_WORD_RST;
		end else if (result_pulse) begin
			light_result_reg <= light_sample_i; // R22
			infrared_result_reg <= ir_sample_i; // R22
		end
	end

	// ----------------------------------------------------------------
	// persistence and event flags
	// ----------------------------------------------------------------
	logic [3:0] persist_cnt_reg;
	logic persist_dir_above_reg;
	logic [3:0] persist_need;
	logic [3:0] persist_cnt_next;

	assign above_now = light_sample_i > upper_threshold_reg;
	assign below_now = light_sample_i < lower_threshold_reg;
	assign persist_need = 4'h1 << pers_sel; // R11
	assign persist_cnt_next = ((above_now != persist_dir_above_reg)
		|| (persist_cnt_reg == 4'h0)) ? 4'h1 : persist_cnt_reg + 4'h1;
	assign persist_hit = result_pulse && (above_now || below_now)
		&& (persist_cnt_next >= persist_need); // R24

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			persist_cnt_reg <= 4'h0;
			persist_dir_above_reg <= 1'b0;
		end else if (result_pulse) begin
			if (above_now || below_now) begin
				persist_dir_above_reg <= above_now;
				persist_cnt_reg <= persist_hit ? 4'h0 : persist_cnt_next; // R24
			end else begin
				persist_cnt_reg <= 4'h0; // R24
			end
		end
	end

	// a set in the same cycle as the clearing read wins
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			single_shot_done_flag_reg <= 1'b0;
			below_window_flag_reg <= 1'b0;
			above_window_flag_reg <= 1'b0;
		end else begin
			if (result_pulse && af_en) begin
				single_shot_done_flag_reg <= 1'b1; // R18
			end else if (flags_read_pulse) begin
				single_shot_done_flag_reg <= 1'b0; // R23
			end
			if (persist_hit && int_en && below_now) begin
				below_window_flag_reg <= 1'b1; // R6 R19
			end else if (flags_read_pulse) begin
				below_window_flag_reg <= 1'b0; // R23
			end
			if (persist_hit && int_en && above_now) begin
				above_window_flag_reg <= 1'b1; // R6 R20
			end else if (flags_read_pulse) begin
				above_window_flag_reg <= 1'b0; // R23
			end
		end
	end

	// open-drain interrupt pulled low while a threshold flag stands and interrupt enable is set
	assign int_o = 1'b0;
	assign int_oe_n_o = ~(int_en & (below_window_flag_reg | above_window_flag_reg)); // R6 R23

endmodule : lsr_top

/* File: verification/lsr_host_model.sv */
// two-wire bus host model: 800 ns serial clock, open-drain data
`timescale 1ns/100ps
`include "lsr_params.svh"

module lsr_host_model (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// ----
	// bit, byte and transfer tasks
	// ----
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	// long first wait lets the device drop its acknowledge before scl rises
	task automatic start;
		sda_o = 1'b1;
		tick(5);
		scl_o = 1'b1;
		tick(3);
		sda_o = 1'b0;
		tick(3);
		scl_o = 1'b0;
	endtask : start
	task automatic stop;
		tick(3);
		sda_o = 1'b0;
		tick(2);
		scl_o = 1'b1;
		tick(3);
		sda_o = 1'b1;
		tick(5);
	endtask : stop
	// low 5 cycles, high 3; data read just before scl falls
	task automatic bit_io(input logic b, output logic r);
		tick(3);
		sda_o = b;
		tick(2);
		scl_o = 1'b1;
		tick(3);
		r = sda_i;
		scl_o = 1'b0;
	endtask : bit_io
	task automatic xfer(input logic [7:0] d, input logic ack_o, output logic [7:0] q,
		output logic ack_i);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(ack_o, ack_i);
	endtask : xfer
	task automatic wr(input logic [6:0] adr, input logic [7:0] cmd, input logic [15:0] d,
		input int n, output logic ack);
		logic [7:0] q;
		logic a;
		start();
		xfer({adr, 1'b0}, 1'b1, q, ack);
		xfer(cmd, 1'b1, q, a);
		for (int i = 0; i < n; i++) xfer(d[8*i +: 8], 1'b1, q, a);
		stop();
	endtask : wr
	task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] d);
		logic [7:0] q;
		logic a;
		d = 16'h0000;
		start();
		xfer({`LSR_BUS_ADDR_A, 1'b0}, 1'b1, q, a);
		xfer(cmd, 1'b1, q, a);
		start();
		xfer({`LSR_BUS_ADDR_A, 1'b1}, 1'b1, q, a);
		for (int i = 0; i < n; i++) begin
			xfer(8'hff, i == n - 1, q, a);
			d[8*i +: 8] = q;
		end
		stop();
	endtask : rd
endmodule : lsr_host_model

/* File: verification/lsr_top_assertions.sv */
// port assertions of the light sensor register block
`timescale 1ns/100ps

module lsr_top_checker #(
	parameter int INTEG_BASE_CYCLES = 20
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire logic int_o,
	input wire logic int_oe_n_o,
	input wire logic measure_active_o,
	input wire logic [2:0] integration_time_sel_o,
	input wire logic reference_powerdown_o,
	input wire logic channels_powerdown_o,
	input wire logic photodiode_quarter_sel_o,
	input wire logic [1:0] gain_sel_o,
	input wire logic post_powerup_set_bit_o
);
	int run_cnt;
	int fall_age;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// ----
	// helpers: run length and cycles since the serial clock fell
	// ----
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			run_cnt <= 0;
		end else begin
			run_cnt <= measure_active_o ? run_cnt + 1 : 0;
		end
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fall_age <= 99;
		end else if ($fell(scl_i)) begin
			fall_age <= 0;
		end else if (fall_age < 99) begin
			fall_age <= fall_age + 1;
		end
	end
	sequence run_end_s;
		$fell(measure_active_o) && !reference_powerdown_o && !channels_powerdown_o;
	endsequence
	sequence near_fall_s;
		fall_age < 10;
	endsequence
	// ----
	// assertions
	// ----
	chk_reset_shutdown: assert property ($past(rst_i) |-> reference_powerdown_o
		&& !channels_powerdown_o && !measure_active_o && gain_sel_o == 2'b00)
		else $error("shutdown values missing after reset");
	chk_run_length: assert property (run_end_s |->
		run_cnt >= (INTEG_BASE_CYCLES << $past(integration_time_sel_o)) - 1
		&& run_cnt <= (INTEG_BASE_CYCLES << $past(integration_time_sel_o)) + 1)
		else $error("integration length wrong");
	chk_no_run_off: assert property ($rose(measure_active_o) |->
		!reference_powerdown_o && !channels_powerdown_o)
		else $error("measurement started while powered down");
	chk_cfg_on_write: assert property ($changed({integration_time_sel_o,
		reference_powerdown_o, channels_powerdown_o, photodiode_quarter_sel_o,
		gain_sel_o, post_powerup_set_bit_o}) |-> near_fall_s)
		else $error("configuration changed without a bus write");
	chk_int_on_result: assert property ($fell(int_oe_n_o) |->
		$past(measure_active_o) || $past(measure_active_o, 2))
		else $error("interrupt asserted away from a result");
	chk_int_release: assert property ($rose(int_oe_n_o) |-> near_fall_s)
		else $error("interrupt released without a bus access");
	chk_oe_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i))
		else $error("data enable changed while serial clock high");
	chk_pins_low: assert property (!sda_o && !int_o)
		else $error("open-drain value not low");
endmodule : lsr_top_checker

bind lsr_top lsr_top_checker #(.INTEG_BASE_CYCLES(INTEG_BASE_CYCLES)) i_lsr_top_checker (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_o(sda_o),
	.sda_oe_n_o(sda_oe_n_o), .int_o(int_o), .int_oe_n_o(int_oe_n_o),
	.measure_active_o(measure_active_o), .integration_time_sel_o(integration_time_sel_o),
	.reference_powerdown_o(reference_powerdown_o), .channels_powerdown_o(channels_powerdown_o),
	.photodiode_quarter_sel_o(photodiode_quarter_sel_o), .gain_sel_o(gain_sel_o),
	.post_powerup_set_bit_o(post_powerup_set_bit_o)
);

/* File: verification/lsr_top_tb.sv */
// self-checking bench of the light sensor register block
`timescale 1ns/100ps
`include "lsr_params.svh"

module lsr_top_tb;
	localparam int BASE = 20;
	localparam logic [7:0] IDC = 8'h3c; // arbitrary value
	localparam logic [3:0] VER = 4'h3; // arbitrary value
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] light_sample_i = 16'h0000;
	logic [15:0] ir_sample_i = 16'h0000;
	logic scl, host_sda, sda, sda_o, sda_oe_n_o, int_o, int_oe_n_o, measure_active_o;
	logic ref_pd, ch_pd, pd_q, cal, a, seen;
	logic [2:0] it_sel;
	logic [1:0] gain;
	logic [15:0] w;
	logic [7:0] p, s;
	logic [31:0] r;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	assign sda = host_sda & (sda_oe_n_o | sda_o);
	always #50 sys_clk_i = ~sys_clk_i;
	lsr_top #(.IDENTITY_CODE(IDC), .VERSION_CODE(VER), .INTEG_BASE_CYCLES(BASE)) i_lsr_top (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o), .int_o(int_o), .int_oe_n_o(int_oe_n_o),
		.light_sample_i(light_sample_i), .ir_sample_i(ir_sample_i),
		.measure_active_o(measure_active_o), .integration_time_sel_o(it_sel),
		.reference_powerdown_o(ref_pd), .channels_powerdown_o(ch_pd),
		.photodiode_quarter_sel_o(pd_q), .gain_sel_o(gain), .post_powerup_set_bit_o(cal));
	lsr_host_model i_lsr_host_model (.clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl),
		.sda_o(host_sda));
	// ----
	// expectations, checks and bus helpers
	// ----
	function automatic logic [7:0] prim(input logic [2:0] it, input logic af,
		input logic trig, input logic ie, input logic pd);
		return {1'b0, it, af, trig, ie, pd};
	endfunction : prim
	function automatic logic [7:0] sec(input logic ch, input logic q, input logic [1:0] g,
		input logic [1:0] pers);
		return {ch, q, 1'b0, g, pers, 1'b1};
	endfunction : sec
	function automatic logic [15:0] flags(input logic d, input logic lo, input logic hi);
		return {12'h000, d, lo, hi, 1'b0};
	endfunction : flags
	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_word
	task automatic check_bit(input logic got, input logic exp);
		check_word({15'h0000, got}, {15'h0000, exp});
	endtask : check_bit
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n);
		i_lsr_host_model.wr(`LSR_BUS_ADDR_A, cmd, d, n, a);
	endtask : wr
	task automatic rd(input logic [7:0] cmd, input int n);
		i_lsr_host_model.rd(cmd, n, w);
	endtask : rd
	task automatic cfg(input logic [7:0] pv, input logic [7:0] sv);
		wr(8'h00, {sv, pv}, 2);
	endtask : cfg
	task automatic shot(input logic [7:0] pv, input logic [7:0] sv, input logic [15:0] smp);
		int k;
		light_sample_i = smp;
		cfg(pv | 8'h04, sv);
		k = 0;
		while (measure_active_o !== 1'b0 && k < 400) begin
			@(posedge sys_clk_i);
			k++;
		end
		repeat (2) @(posedge sys_clk_i);
		#1;
	endtask : shot
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			n_fail++;
			print_verdict();
		end
	end
	// ----
	// tests
	// ----
	initial begin
		void'($urandom(41664));
		repeat (4) @(posedge sys_clk_i);
		#1;
		rst_i = 1'b0;
		repeat (3) @(posedge sys_clk_i);
		#1;
		check_word({8'h00, ch_pd, pd_q, gain, it_sel, ref_pd}, 16'h0001);
		rd(8'h00, 1);
		check_word(w, 16'h0001);
		rd(8'h14, 2);
		check_word(w, {`LSR_PACKAGE_CODE, `LSR_ADDR_OPT_A, VER, IDC});
		rd(8'h16, 1);
		check_word(w, 16'h0000);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			p = prim(i[2:0], 1'b0, 1'b0, r[0], 1'b1);
			s = sec(r[1], r[2], i[1:0], r[4:3]);
			cfg(p, s);
			check_bit(a, 1'b0);
			check_word({8'h00, ch_pd, pd_q, gain, it_sel, ref_pd},
				{8'h00, s[7], s[6], s[4:3], p[6:4], p[0]});
			check_bit(cal, 1'b1);
			rd(8'h00, 2);
			check_word(w, {s, p});
		end
		$display("configuration test done");
		r = $urandom;
		wr(8'h04, r[15:0], 2);
		wr(8'h06, r[31:16], 2);
		wr(8'h10, ~r[15:0], 2);
		rd(8'h04, 2);
		check_word(w, r[15:0]);
		rd(8'h06, 2);
		check_word(w, r[31:16]);
		rd(8'h10, 2);
		check_word(w, 16'h0000);
		$display("threshold test done");
		r = $urandom;
		light_sample_i = r[15:0];
		ir_sample_i = r[31:16];
		cfg(prim(3'h0, 1'b0, 1'b0, 1'b0, 1'b0), sec(1'b0, 1'b0, 2'b00, 2'b00));
		rd(8'h10, 2);
		check_word(w, r[15:0]);
		rd(8'h12, 2);
		check_word(w, r[31:16]);
		cfg(prim(3'h0, 1'b0, 1'b0, 1'b0, 1'b1), sec(1'b1, 1'b0, 2'b00, 2'b00));
		light_sample_i = ~r[15:0];
		ir_sample_i = ~r[31:16];
		rd(8'h10, 2);
		check_word(w, r[15:0]);
		rd(8'h12, 2);
		check_word(w, r[31:16]);
		$display("continuous test done");
		p = prim(3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
		s = sec(1'b0, 1'b0, 2'b00, 2'b00);
		cfg(p, s);
		seen = 1'b0;
		repeat (100) begin
			@(posedge sys_clk_i);
			#1;
			seen = seen | measure_active_o;
		end
		check_bit(seen, 1'b0);
		r = $urandom;
		shot(p, s, r[15:0]);
		rd(8'h00, 1);
		check_word(w, {8'h00, p});
		rd(8'h10, 2);
		check_word(w, r[15:0]);
		rd(8'h17, 1);
		check_word(w, flags(1'b1, 1'b0, 1'b0));
		rd(8'h17, 1);
		check_word(w, 16'h0000);
		$display("single-shot test done");
		wr(8'h04, 16'h1000, 2);
		wr(8'h06, 16'h0100, 2);
		for (int c = 0; c < 4; c++) begin
			p = prim(c[2:0], 1'b1, 1'b0, 1'b1, 1'b0);
			s = sec(1'b0, 1'b0, 2'b00, c[1:0]);
			shot(p, s, 16'h1000);
			rd(8'h17, 1);
			repeat ((1 << c) - 1) shot(p, s, 16'h1001);
			check_bit(int_oe_n_o, 1'b1);
			rd(8'h17, 1);
			check_word(w, flags(c != 0, 1'b0, 1'b0));
			shot(p, s, 16'h1001 + 16'($urandom_range(0, 16'h0fff)));
			check_bit(int_oe_n_o, 1'b0);
			rd(8'h17, 1);
			check_word(w, flags(1'b1, 1'b0, 1'b1));
			check_bit(int_oe_n_o, 1'b1);
		end
		$display("persistence test done");
		p = prim(3'h0, 1'b1, 1'b0, 1'b1, 1'b0);
		s = sec(1'b0, 1'b0, 2'b00, 2'b00);
		shot(p, s, 16'h0100);
		rd(8'h17, 1);
		check_word(w, flags(1'b1, 1'b0, 1'b0));
		shot(p, s, 16'h00ff);
		rd(8'h17, 1);
		check_word(w, flags(1'b1, 1'b1, 1'b0));
		p = prim(3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
		shot(p, s, 16'h2000);
		check_bit(int_oe_n_o, 1'b1);
		rd(8'h17, 1);
		check_word(w, flags(1'b1, 1'b0, 1'b0));
		i_lsr_host_model.wr(7'h2a, 8'h04, 16'hffff, 2, a);
		check_bit(a, 1'b1);
		rd(8'h04, 2);
		check_word(w, 16'h1000);
		$display("window and address test done");
		print_verdict();
	end
endmodule : lsr_top_tb
